// ### rtl/stpg_gate.sv
// spanning tree port gate: apb registers, frame gating, learning and flush
`timescale 1ns/1ps
`default_nettype none
`include "stpg_map.svh"

module stpg_gate
    import stpg_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // ingress frame stream
    input  wire logic        IN_VALID,
    output logic             IN_READY,
    input  wire stpg_in_s    IN_BEAT,
    // egress frame stream
    output logic             OUT_VALID,
    input  wire logic        OUT_READY,
    output stpg_out_s        OUT_BEAT,
    // address table side
    output logic             LEARN_VALID,
    output logic      [1:0]  LEARN_PORT,
    output logic      [1:0]  FLUSH_DYN,
    output logic      [1:0]  FLUSH_STA
);

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    ////////////////////////////////////////////////////////////////////////////
    // register file

    logic [7:0]  port1_reg;
    logic [7:0]  port2_reg;
    logic [7:0]  global2;
    logic [15:0] drop_cnt;
    stpg_ctrl_s  cfg [2];
    stpg_ctrl_s  eff [2];
    logic [9:0]  idx;
    logic        setup;
    logic        wr_acc;
    logic        hit;
    logic [31:0] next_rdata;

    assign idx    = PADDR[11:2];
    assign setup  = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;
    assign hit    = (idx == `STPG_IDX_GLOBAL2) || (idx == `STPG_IDX_PORT1) ||
                    (idx == `STPG_IDX_PORT2) || (idx == `STPG_IDX_STATUS);

    // RULE2 three controls per port
    assign cfg[0] = '{tx_en:     port1_reg[`STPG_BIT_TXEN],
                      rx_en:     port1_reg[`STPG_BIT_RXEN],
                      learn_dis: port1_reg[`STPG_BIT_LDIS]};
    assign cfg[1] = '{tx_en:     port2_reg[`STPG_BIT_TXEN],
                      rx_en:     port2_reg[`STPG_BIT_RXEN],
                      learn_dis: port2_reg[`STPG_BIT_LDIS]};

    function automatic stpg_state_e decode(input stpg_ctrl_s c);
        unique case ({c.tx_en, c.rx_en, c.learn_dis})
            3'b001:  decode = STPG_ST_DISCARD;
            3'b000:  decode = STPG_ST_LEARN;
            3'b110:  decode = STPG_ST_FORWARD;
            default: decode = STPG_ST_OTHER;
        endcase
    endfunction

    // RULE1 only ports 1 and 2 hold state controls
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            port1_reg <= `STPG_PORT_RESET;
            port2_reg <= `STPG_PORT_RESET;
            global2   <= `STPG_GLOBAL2_RESET;
        end
        else if (wr_acc)
        begin
            if (idx == `STPG_IDX_PORT1)
            begin
                port1_reg <= PWDATA[7:0];
            end
            if (idx == `STPG_IDX_PORT2)
            begin
                port2_reg <= PWDATA[7:0];
            end
            // flush bits act once and read back as zero
            if (idx == `STPG_IDX_GLOBAL2)
            begin
                global2 <= PWDATA[7:0] & ~8'h30;
            end
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (idx)
            `STPG_IDX_GLOBAL2: next_rdata[7:0] = global2;
            `STPG_IDX_PORT1:   next_rdata[7:0] = port1_reg;
            `STPG_IDX_PORT2:   next_rdata[7:0] = port2_reg;
            `STPG_IDX_STATUS:
            begin
                next_rdata[2:0]   = eff[0];
                next_rdata[6:4]   = eff[1];
                next_rdata[9:8]   = decode(eff[0]);
                next_rdata[11:10] = decode(eff[1]);
                next_rdata[31:16] = drop_cnt;
            end
            default:           next_rdata = 32'h0000_0000;
        endcase
    end

    // read data and error are caught in the setup cycle
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else if (setup)
        begin
            PRDATA  <= PWRITE ? 32'h0000_0000 : next_rdata;
            PSLVERR <= !hit;
        end
        else if (!PSEL)
        begin
            PSLVERR <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flush of table entries

    // RULE13 flush ports whose learning is off
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            FLUSH_DYN <= 2'h0;
            FLUSH_STA <= 2'h0;
        end
        else
        begin
            FLUSH_DYN <= 2'h0;
            FLUSH_STA <= 2'h0;
            if (wr_acc && idx == `STPG_IDX_GLOBAL2)
            begin
                if (PWDATA[`STPG_BIT_FLUSH_DYN])
                begin
                    FLUSH_DYN <= {cfg[1].learn_dis, cfg[0].learn_dis};
                end
                if (PWDATA[`STPG_BIT_FLUSH_STA])
                begin
                    FLUSH_STA <= {cfg[1].learn_dis, cfg[0].learn_dis};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // controls applied at frame boundaries

    logic fire;
    logic beat;
    logic in_frame;

    assign beat = IN_VALID && IN_READY;
    assign fire = beat && IN_BEAT.sop;

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            in_frame <= 1'b0;
        end
        else if (beat)
        begin
            in_frame <= !IN_BEAT.eop;
        end
    end

    // RULE15 controls only move between frames
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            eff[0] <= '{tx_en: 1'b1, rx_en: 1'b1, learn_dis: 1'b0};
            eff[1] <= '{tx_en: 1'b1, rx_en: 1'b1, learn_dis: 1'b0};
        end
        else if (!in_frame)
        begin
            eff[0] <= cfg[0];
            eff[1] <= cfg[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // forwarding decision on the first beat

    logic [2:0] dec_dst;
    logic [2:0] tx_mask;
    logic [2:0] own_bit;
    logic       src_user;
    logic       sel;
    logic [7:0] dec_tag;

    assign src_user = (IN_BEAT.src == `STPG_SRC_P1) || (IN_BEAT.src == `STPG_SRC_P2);
    assign sel      = (IN_BEAT.src == `STPG_SRC_P2);
    // the processor port always accepts
    assign tx_mask  = {1'b1, eff[1].tx_en, eff[0].tx_en};
    assign own_bit  = sel ? 3'h2 : 3'h1;
    // RULE14 egress tag names the source port
    assign dec_tag  = sel ? `STPG_TAG_FROM_P2 : `STPG_TAG_FROM_P1;

    always_comb
    begin
        dec_dst = 3'h0;
        if (IN_BEAT.src == `STPG_SRC_CPU)
        begin
            // RULE6 RULE14 tail tag steers processor frames
            if (IN_BEAT.tag != 2'h0)
            begin
                dec_dst = {1'b0, IN_BEAT.tag};
            end
            else
            begin
                dec_dst = IN_BEAT.dst & {1'b0, eff[1].tx_en, eff[0].tx_en};
            end
        end
        else if (src_user)
        begin
            // RULE8 normal forwarding when receive is on
            if (eff[sel].rx_en)
            begin
                dec_dst = IN_BEAT.dst & tx_mask & ~own_bit;
            end
            // RULE4 RULE5 override matches still reach the processor
            else if (IN_BEAT.ovr && IN_BEAT.dst[2])
            begin
                dec_dst = `STPG_DST_CPU;
            end
            // RULE3 RULE12 RULE16 everything else dropped
            else
            begin
                dec_dst = 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // egress path through the fifo

    logic       keep;
    logic [2:0] frm_dst;
    logic [7:0] frm_tag;
    logic       push;
    stpg_out_s  push_beat;

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            keep    <= 1'b0;
            frm_dst <= 3'h0;
            frm_tag <= 8'h00;
        end
        else if (fire)
        begin
            keep    <= (dec_dst != 3'h0);
            frm_dst <= dec_dst;
            frm_tag <= dec_tag;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            drop_cnt <= 16'h0000;
        end
        else if (fire && dec_dst == 3'h0 && drop_cnt != 16'hFFFF)
        begin
            drop_cnt <= drop_cnt + 16'h0001;
        end
    end

    assign push = IN_VALID && (IN_BEAT.sop ? (dec_dst != 3'h0) : keep);
    assign push_beat = '{data: IN_BEAT.data,
                         sop:  IN_BEAT.sop,
                         eop:  IN_BEAT.eop,
                         dst:  IN_BEAT.sop ? dec_dst : frm_dst,
                         tag:  IN_BEAT.sop ? dec_tag : frm_tag};

    // a full fifo stalls the source, dropped beats wait too
    stpg_fifo #(
        .WIDTH ($bits(stpg_out_s)),
        .DEPTH (`STPG_FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK_SYS),
        .rst_n     (RST_N),
        .in_valid  (push),
        .in_ready  (IN_READY),
        .in_data   (push_beat),
        .out_valid (OUT_VALID),
        .out_ready (OUT_READY),
        .out_data  (OUT_BEAT)
    );

    ////////////////////////////////////////////////////////////////////////////
    // source address learning

    // RULE7 RULE8 learn unless learning is disabled
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            LEARN_VALID <= 1'b0;
            LEARN_PORT  <= 2'h0;
        end
        else
        begin
            LEARN_VALID <= fire && src_user && !eff[sel].learn_dis;
            if (fire && src_user)
            begin
                LEARN_PORT <= IN_BEAT.src;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    chk_ctrl_write: assert property ( // RULE2
        wr_acc && idx == `STPG_IDX_PORT1 |=> cfg[0].rx_en == $past(PWDATA[`STPG_BIT_RXEN]))
        else $error("port 1 control write lost");

    chk_disable_drop: assert property ( // RULE3
        fire && src_user && !eff[sel].rx_en && !IN_BEAT.ovr |-> dec_dst == 3'h0)
        else $error("frame from receive-off port not dropped");

    chk_override_cpu: assert property ( // RULE4
        fire && src_user && !eff[sel].rx_en && IN_BEAT.ovr && IN_BEAT.dst[2]
        |-> dec_dst == `STPG_DST_CPU ##1 keep)
        else $error("override frame not sent to processor");

    chk_blocked_nolearn: assert property ( // RULE5
        fire && src_user && eff[sel].learn_dis |=> !LEARN_VALID)
        else $error("learning while disabled");

    chk_cpu_steer: assert property ( // RULE6
        fire && IN_BEAT.src == `STPG_SRC_CPU && IN_BEAT.tag == 2'h2 |-> dec_dst == 3'h2)
        else $error("tail tag steering wrong");

    chk_learn_pulse: assert property ( // RULE7
        fire && src_user && !eff[sel].learn_dis
        |=> LEARN_VALID && LEARN_PORT == $past(IN_BEAT.src) ##1 !LEARN_VALID || $past(fire))
        else $error("learn request missing");

    chk_forward_mask: assert property ( // RULE8
        fire && src_user && eff[sel].rx_en |-> dec_dst == (IN_BEAT.dst & tx_mask & ~own_bit))
        else $error("forwarding mask wrong");

    chk_rstp_discard: assert property ( // RULE12
        fire && src_user && decode(eff[sel]) == STPG_ST_DISCARD
        |-> (dec_dst & 3'h3) == 3'h0 ##1 !LEARN_VALID)
        else $error("discarding port passed traffic");

    chk_flush_port: assert property ( // RULE13
        wr_acc && idx == `STPG_IDX_GLOBAL2 && PWDATA[`STPG_BIT_FLUSH_DYN] && cfg[0].learn_dis
        |=> FLUSH_DYN[0] ##1 !FLUSH_DYN[0] || $past(wr_acc))
        else $error("dynamic flush missing");

    chk_tag_source: assert property ( // RULE14
        fire && IN_BEAT.src == `STPG_SRC_P2 && dec_dst != 3'h0 |=> frm_tag[0])
        else $error("egress tag source wrong");

    chk_frame_stable: assert property ( // RULE15
        in_frame |=> $stable(eff[0]) && $stable(eff[1]))
        else $error("controls changed mid frame");

endmodule

`default_nettype wire

// ### shared/stpg_map.svh
// register map, field positions and reset values of the spanning tree port gate
//
// Functional notes
// RULE1 - Port 3 is the processor port and only ports 1 and 2 have spanning tree controls.
// RULE2 - Ports 1 and 2 each have transmit enable, receive enable and learning disable that select the port state.
// RULE3 - With all three controls at 0, 0, 1 the port neither forwards nor receives ordinary frames and does not learn.
// RULE4 - A port with receive off still hands override-marked static matches to the processor port.
// RULE5 - In blocking only frames for the processor get through and the port learns nothing.
// RULE6 - In listening only traffic to or from the processor passes and learning stays off.
// RULE7 - With controls 0, 0, 0 only processor traffic passes but source addresses are learned.
// RULE8 - With controls 1, 1, 0 all traffic flows normally and source addresses are learned.
// RULE9 - The processor steers frames by tail tag only to ports in listening, learning or forwarding.
// RULE10 - The processor loads static entries with the override bit for the frames it must receive.
// RULE11 - The processor drops override frames that still arrive from a disabled or discarding port.
// RULE12 - The rapid discarding state uses controls 0, 0, 1 and so neither forwards nor learns.
// RULE13 - Setting global bits 5 and 4 flushes the dynamic and static entries of each port whose learning is off.
// RULE14 - The low two bits of the tail tag byte name the source or destination port at the processor port.
// RULE15 - Control changes take effect only between frames so that no frame is cut.
// RULE16 - A port with receive off drops ingress frames unless an override static match sends them to the processor.
`ifndef STPG_MAP_SVH
`define STPG_MAP_SVH

// register indices; byte address is four times the index
`define STPG_IDX_GLOBAL2    10'h002
`define STPG_IDX_PORT1      10'h012
`define STPG_IDX_PORT2      10'h022
`define STPG_IDX_STATUS     10'h040

// port control fields
`define STPG_BIT_TXEN       2
`define STPG_BIT_RXEN       1
`define STPG_BIT_LDIS       0
`define STPG_PORT_RESET     8'h06

// global register 2 fields
`define STPG_BIT_FLUSH_DYN  5
`define STPG_BIT_FLUSH_STA  4
`define STPG_GLOBAL2_RESET  8'h00

// port codes on the stream
`define STPG_SRC_P1         2'h1
`define STPG_SRC_P2         2'h2
`define STPG_SRC_CPU        2'h3
`define STPG_DST_CPU        3'h4

// egress tail tag values toward the processor
`define STPG_TAG_FROM_P1    8'h00
`define STPG_TAG_FROM_P2    8'h01

// buffering
`define STPG_FIFO_DEPTH     4

`endif

// ### shared/stpg_pkg.sv
// types of the spanning tree port gate
package stpg_pkg;

    // one ingress beat; header fields are read on the first beat
    typedef struct packed {
        logic [31:0] data;
        logic        sop;
        logic        eop;
        logic [1:0]  src;
        logic [2:0]  dst;
        logic        ovr;
        logic [1:0]  tag;
    } stpg_in_s;

    // one egress beat
    typedef struct packed {
        logic [31:0] data;
        logic        sop;
        logic        eop;
        logic [2:0]  dst;
        logic [7:0]  tag;
    } stpg_out_s;

    // per port controls
    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic learn_dis;
    } stpg_ctrl_s;

    typedef enum logic [1:0] {
        STPG_ST_DISCARD = 2'b00,
        STPG_ST_LEARN   = 2'b01,
        STPG_ST_FORWARD = 2'b10,
        STPG_ST_OTHER   = 2'b11
    } stpg_state_e;

endpackage

// ### rtl/stpg_fifo.sv
// small valid/ready fifo in the egress path
`timescale 1ns/1ps
`default_nettype none

module stpg_fifo
    import stpg_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    // depth must be a power of two so the pointers wrap by themselves
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ### verification/stpg_host.sv
// host processor model draining the egress stream
`timescale 1ns/1ps
`default_nettype none

module stpg_host
    import stpg_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // egress stream
    input  wire logic       valid,
    output logic            ready,
    input  wire stpg_out_s  beat,
    // pacing and capture
    input  wire logic [1:0] pace,
    output logic            got,
    output stpg_out_s       got_beat
);
    logic [1:0] cnt;

    // pace 0 prompt, 1 slow, 2 or 3 stalled
    assign ready = rst_n && (pace == 2'h0 || (pace == 2'h1 && cnt == 2'h0));

    always_ff @(posedge clk)
    begin
        cnt <= rst_n ? cnt + 2'h1 : 2'h0;
        got <= rst_n && valid && ready;
        if (valid && ready)
            got_beat <= beat;
    end
endmodule
`default_nettype wire

// ### verification/stpg_gate_tb.sv
// self-checking bench of the spanning tree port gate
`timescale 1ns/1ps
`default_nettype none
`include "stpg_map.svh"

module stpg_gate_tb
    import stpg_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        in_valid = 1'b0;
    logic        in_ready;
    stpg_in_s    in_beat = '0;
    logic        out_valid;
    logic        out_ready;
    stpg_out_s   out_beat;
    logic        lv;
    logic [1:0]  lp;
    logic [1:0]  fdyn;
    logic [1:0]  fsta;
    logic [1:0]  pace = 2'h0;
    logic        got;
    stpg_out_s   gb;
    logic [31:0] seed = 32'h03B4;
    logic [2:0]  ctl [3];
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          n_drop = 0;
    int          cyc = 0;
    stpg_out_s   exp_q [$];
    logic        chk_q [$];
    logic [1:0]  el [$];
    logic [1:0]  gl [$];
    logic [3:0]  fq [$];
    logic [2:0]  fd;
    logic [7:0]  ft;
    logic        fc;

    always #5 clk = ~clk;

    stpg_gate i_dut (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .IN_VALID(in_valid), .IN_READY(in_ready), .IN_BEAT(in_beat), .OUT_VALID(out_valid),
        .OUT_READY(out_ready), .OUT_BEAT(out_beat), .LEARN_VALID(lv), .LEARN_PORT(lp),
        .FLUSH_DYN(fdyn), .FLUSH_STA(fsta));

    stpg_host i_host (.clk(clk), .rst_n(rst_n), .valid(out_valid), .ready(out_ready), .beat(out_beat),
        .pace(pace), .got(got), .got_beat(gb));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [1:0] st(input logic [2:0] c);
        return c == 3'h1 ? 2'h0 : c == 3'h0 ? 2'h1 : c == 3'h6 ? 2'h2 : 2'h3;
    endfunction

    task automatic finish_test();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmp_beat(input stpg_out_s g, input stpg_out_s e, input logic c);
        stpg_out_s m;
        m = '1;
        if (!c)
            m.tag = 8'h00;
        cmp_count++;
        if ((g & m) !== (e & m))
        begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       input logic [31:0] er, input logic [31:0] mk, input logic ee);
        logic [31:0] rd;
        logic        err;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        cmp_word(32'(err), 32'(ee));
        if (!wr)
            cmp_word(rd & mk, er);
        if (wr && idx == `STPG_IDX_PORT1)
            ctl[1] = wd[2:0];
        if (wr && idx == `STPG_IDX_PORT2)
            ctl[2] = wd[2:0];
    endtask

    // one ingress beat; the frame's fate is decided on its first beat
    task automatic beat(input stpg_in_s b);
        logic [1:0] p;
        p = b.src;
        if (b.sop)
        begin
            fc = (p == 2'h1 || p == 2'h2);
            ft = (p == 2'h2) ? `STPG_TAG_FROM_P2 : `STPG_TAG_FROM_P1;
            fd = 3'h0;
            if (fc && ctl[p][`STPG_BIT_RXEN])
                fd = b.dst & {1'b1, ctl[2][`STPG_BIT_TXEN], ctl[1][`STPG_BIT_TXEN]};
            else if (fc && b.ovr)
                fd = b.dst & 3'h4;
            else if (p == 2'h3 && b.tag != 2'h0)
                fd = {1'b0, b.tag};
            else if (p == 2'h3)
                fd = b.dst & {1'b0, ctl[2][`STPG_BIT_TXEN], ctl[1][`STPG_BIT_TXEN]};
            if (fc && !ctl[p][`STPG_BIT_LDIS])
                el.push_back(p);
            if (fd == 3'h0)
                n_drop++;
        end
        if (fd != 3'h0)
        begin
            exp_q.push_back({b.data, b.sop, b.eop, fd, ft});
            chk_q.push_back(fc);
        end
        in_valid <= 1'b1;
        in_beat  <= b;
        do @(posedge clk); while (in_ready !== 1'b1);
    endtask

    task automatic frame(input int n);
        stpg_in_s    h;
        logic [31:0] r;
        r = rnd();
        h = '0;
        h.src = r[1:0];
        h.ovr = r[2];
        h.tag = r[4:3] & {~ctl[2][0], ~ctl[1][0]};
        h.dst = r[7:5] & ~{h.src == 2'h3, h.src == 2'h2, h.src == 2'h1};
        @(posedge clk);
        pace <= {1'b0, r[8]};
        for (int i = 0; i < n; i++)
        begin
            h.data = rnd();
            h.sop = (i == 0);
            h.eop = (i == n - 1);
            beat(h);
        end
        in_valid <= 1'b0;
    endtask

    task automatic drain();
        while (exp_q.size() > 0) @(posedge clk);
        repeat (3) @(posedge clk);
        cmp_word(32'(out_valid), 32'h0);
        cmp_word(32'(gl.size()), 32'(el.size()));
        while (el.size() > 0 && gl.size() > 0)
            cmp_word(32'(gl.pop_front()), 32'(el.pop_front()));
        el.delete();
        gl.delete();
    endtask

    task automatic flush(input logic [7:0] g);
        logic [1:0] l;
        l = {ctl[2][0], ctl[1][0]};
        apb(1'b1, `STPG_IDX_GLOBAL2, {24'h0, g}, 32'h0, 32'h0, 1'b0);
        repeat (3) @(posedge clk);
        cmp_word(32'(fq.size()), 32'((g[5] | g[4]) && l != 2'h0));
        if (fq.size() > 0)
            cmp_word(32'(fq[0]), {28'h0, g[4] ? l : 2'h0, g[5] ? l : 2'h0});
        fq.delete();
        apb(1'b0, `STPG_IDX_GLOBAL2, 32'h0, {24'h0, g & 8'hCF}, 32'hFFFFFFFF, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (got && exp_q.size() == 0)
            cmp_word(32'h1, 32'h0);
        else if (got)
            cmp_beat(gb, exp_q.pop_front(), chk_q.pop_front());
        if (lv && lp != 2'h3)
            gl.push_back(lp);
        if ({fsta, fdyn} != 4'h0)
            fq.push_back({fsta, fdyn});
        if (cyc == 20000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    initial
    begin
        logic [2:0]  cv [3];
        logic [7:0]  gv [3];
        logic [31:0] r;
        stpg_in_s    b;
        cv = '{3'h1, 3'h0, 3'h6};
        gv = '{8'h30, 8'h2B, 8'h14};
        ctl[0] = 3'h0;
        ctl[1] = 3'h6;
        ctl[2] = 3'h6;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `STPG_IDX_PORT1, 32'h0, 32'h6, 32'hFFFFFFFF, 1'b0);
        apb(1'b0, `STPG_IDX_PORT2, 32'h0, 32'h6, 32'hFFFFFFFF, 1'b0);
        apb(1'b0, `STPG_IDX_GLOBAL2, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
        apb(1'b0, 10'h003, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, 10'h3FF, rnd(), 32'h0, 32'h0, 1'b1);
        // every pairing of discarding, learning and forwarding
        for (int k = 0; k < 9; k++)
        begin
            r = rnd();
            apb(1'b1, `STPG_IDX_PORT1, {r[31:8], 5'h0, cv[k % 3]}, 32'h0, 32'h0, 1'b0);
            apb(1'b1, `STPG_IDX_PORT2, {r[31:8], 5'h0, cv[k / 3]}, 32'h0, 32'h0, 1'b0);
            apb(1'b0, `STPG_IDX_STATUS, 32'h0, {n_drop[15:0], 4'h0, st(cv[k / 3]), st(cv[k % 3]), 1'b0,
                cv[k / 3], 1'b0, cv[k % 3]}, 32'hFFFFFFFF, 1'b0);
            repeat (6) frame(1 + int'(rnd() % 32'h2));
            drain();
            flush(gv[k % 3]);
        end
        // control change in mid-frame lands only after the frame
        apb(1'b1, `STPG_IDX_PORT1, 32'h6, 32'h0, 32'h0, 1'b0);
        apb(1'b1, `STPG_IDX_PORT2, 32'h6, 32'h0, 32'h0, 1'b0);
        @(posedge clk);
        b = '0;
        b.src = 2'h1;
        b.dst = 3'h4;
        b.sop = 1'b1;
        b.data = rnd();
        beat(b);
        in_valid <= 1'b0;
        apb(1'b1, `STPG_IDX_PORT1, 32'h1, 32'h0, 32'h0, 1'b0);
        b.sop = 1'b0;
        b.eop = 1'b1;
        b.data = rnd();
        beat(b);
        in_valid <= 1'b0;
        drain();
        // fill the egress buffer against a stalled host, then drain slowly
        apb(1'b1, `STPG_IDX_PORT1, 32'h6, 32'h0, 32'h0, 1'b0);
        apb(1'b1, `STPG_IDX_PORT2, 32'h7, 32'h0, 32'h0, 1'b0);
        apb(1'b0, `STPG_IDX_STATUS, 32'h0, {n_drop[15:0], 16'h0E76}, 32'hFFFFFFFF, 1'b0);
        @(posedge clk);
        pace <= 2'h2;
        b.sop = 1'b1;
        repeat (4)
        begin
            b.data = rnd();
            beat(b);
        end
        in_valid <= 1'b0;
        @(posedge clk);
        cmp_word(32'(in_ready), 32'h0);
        cmp_word(32'(out_valid), 32'h1);
        pace <= 2'h1;
        drain();
        finish_test();
    end
endmodule
`default_nettype wire
